// ---- inc/dft_consts.svh ----
`ifndef DFT_CONSTS_SVH
`define DFT_CONSTS_SVH

// Register offsets
`define DFT_OFS_TARGET_A  8'h33
`define DFT_OFS_TARGET_L  8'h34
`define DFT_OFS_TARGET_B  8'h35
`define DFT_OFS_CTL_ONE   8'h36
`define DFT_OFS_CTL_TWO   8'h37
`define DFT_OFS_LOW_A     8'h4E
`define DFT_OFS_HIGH_A    8'h4F
`define DFT_OFS_LOW_L     8'h50
`define DFT_OFS_HIGH_L    8'h51
`define DFT_OFS_LOW_B     8'h52
`define DFT_OFS_HIGH_B    8'h53

// Reset values
`define DFT_RST_TARGET    8'hA4
`define DFT_RST_LOW       8'h01
`define DFT_RST_HIGH      8'h7F
`define DFT_RST_CTL       8'h00
`define DFT_RST_THRESHOLD 8'h00

// Field positions
`define DFT_EN_A_BIT      5
`define DFT_EN_L_BIT      6
`define DFT_EN_B_BIT      7
`define DFT_CODE_B_MSB    0
`define DFT_CODE_A_LSB    0
`define DFT_CODE_L_LSB    3
`define DFT_CODE_B_LSB    6

// Timing: short cycle base length in monitoring cycles
`define DFT_SHORT_BASE    11'h008

// Offset-64 encoding bias, degrees
`define DFT_BIAS64        10'h040

// Threshold floors in quarter degrees: -127 and -64
`define DFT_FLOOR_TC_Q    13'h1E04
`define DFT_FLOOR_O64_Q   13'h1F00

`endif

// ---- inc/dft_pkg.sv ----
package dft_pkg;

  // One measured temperature: 8-bit code plus quarter-degree fraction
  typedef struct packed {
    logic [7:0] code;
    logic [1:0] frac;
  } dft_temp_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dft_reg_req_t;

  // Per-channel threshold preload from the fan control setup
  typedef struct packed {
    logic       load;
    logic [7:0] value;
  } dft_thr_load_t;

endpackage

// ---- rtl/dft_cycle_timer.sv ----
`include "dft_consts.svh"

// Counts monitoring ticks and marks short and long cycle ends
module dft_cycle_timer (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       tick,
  input  wire logic [2:0] code,
  output logic            short_pulse,
  output logic            long_pulse
);

  logic [10:0] count;
  logic [10:0] short_len;
  logic [10:0] long_len;
  logic        at_short;
  logic        at_long;

  // Short length is 8 << code, long is twice that
  assign short_len = `DFT_SHORT_BASE << code;
  assign long_len  = {short_len[9:0], 1'b0};
  assign at_short  = tick && (count == short_len - 11'h001);
  assign at_long   = tick && (count >= long_len - 11'h001);

  // Wrap on the long boundary; a code change that leaves count
  // beyond the new length still ends cleanly at the next tick
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count <= 11'h000;
    end else if (at_long) begin
      count <= 11'h000;
    end else if (tick) begin
      count <= count + 11'h001;
    end
  end

  // Pulses registered; every long end is also a short end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      short_pulse <= 1'b0;
      long_pulse  <= 1'b0;
    end else begin
      short_pulse <= at_short || at_long;
      long_pulse  <= at_long;
    end
  end

endmodule

// ---- rtl/dft_loop.sv ----
`include "dft_consts.svh"

module dft_loop (
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire dft_pkg::dft_reg_req_t    reg_req,
  output logic [7:0]                    reg_rdata,
  input  wire logic                     monitor_tick,
  input  wire logic                     offset64_mode,
  input  wire dft_pkg::dft_temp_t [2:0] temperature,
  input  wire logic [2:0][7:0]          hysteresis,
  input  wire dft_pkg::dft_thr_load_t [2:0] thr_load,
  output logic [2:0][7:0]               fan_on_threshold,
  output logic [2:0]                    low_event,
  output logic [2:0]                    high_event
);

  // Channel order everywhere: 0 remote A, 1 onchip, 2 remote B
  logic [2:0][7:0] target_temperature;
  logic [2:0][7:0] low_limit;
  logic [2:0][7:0] high_limit;
  logic [7:0]      dynamic_control_one;
  logic [7:0]      dynamic_control_two;

  logic [2:0][2:0] period_code;
  logic [2:0]      adjust_enable;
  logic [2:0]      short_pulse;
  logic [2:0]      long_pulse;

  // Decode an 8-bit code into signed degrees
  function automatic logic signed [9:0] to_deg(
    input logic [7:0] x,
    input logic       o64
  );
    logic [9:0] r;
    if (o64) begin
      r = {2'b00, x} - `DFT_BIAS64;
    end else begin
      r = {{2{x[7]}}, x};
    end
    return $signed(r);
  endfunction

  // Encode signed degrees back to an 8-bit code
  function automatic logic [7:0] to_code(
    input logic [9:0] d,
    input logic       o64
  );
    logic [9:0] r;
    if (o64) begin
      r = d + `DFT_BIAS64;
    end else begin
      r = d;
    end
    return r[7:0];
  endfunction

  // Whole degrees to quarter degrees, 13-bit signed
  function automatic logic signed [12:0] to_q(input logic [9:0] d);
    return $signed({d[9], d, 2'b00});
  endfunction

  // Period codes and enables from the two control registers
  assign period_code[0] = dynamic_control_two[`DFT_CODE_A_LSB +: 3];
  assign period_code[1] = dynamic_control_two[`DFT_CODE_L_LSB +: 3];
  assign period_code[2] = {dynamic_control_one[`DFT_CODE_B_MSB],
                           dynamic_control_two[`DFT_CODE_B_LSB +: 2]};
  // Split remote B code, bit 0 of ctl one on top
  assign adjust_enable  = {dynamic_control_one[`DFT_EN_B_BIT],
                           dynamic_control_one[`DFT_EN_L_BIT],
                           dynamic_control_one[`DFT_EN_A_BIT]};

  // Register writes; bits [4:1] of ctl one are kept but steer nothing
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      target_temperature  <= {3{`DFT_RST_TARGET}};
      low_limit           <= {3{`DFT_RST_LOW}};
      high_limit          <= {3{`DFT_RST_HIGH}};
      dynamic_control_one <= `DFT_RST_CTL;
      dynamic_control_two <= `DFT_RST_CTL;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        `DFT_OFS_TARGET_A: target_temperature[0] <= reg_req.wdata;
        `DFT_OFS_TARGET_L: target_temperature[1] <= reg_req.wdata;
        `DFT_OFS_TARGET_B: target_temperature[2] <= reg_req.wdata;
        `DFT_OFS_CTL_ONE:  dynamic_control_one   <= reg_req.wdata;
        `DFT_OFS_CTL_TWO:  dynamic_control_two   <= reg_req.wdata;
        `DFT_OFS_LOW_A:    low_limit[0]          <= reg_req.wdata;
        `DFT_OFS_HIGH_A:   high_limit[0]         <= reg_req.wdata;
        `DFT_OFS_LOW_L:    low_limit[1]          <= reg_req.wdata;
        `DFT_OFS_HIGH_L:   high_limit[1]         <= reg_req.wdata;
        `DFT_OFS_LOW_B:    low_limit[2]          <= reg_req.wdata;
        `DFT_OFS_HIGH_B:   high_limit[2]         <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `DFT_OFS_TARGET_A: reg_rdata <= target_temperature[0];
        `DFT_OFS_TARGET_L: reg_rdata <= target_temperature[1];
        `DFT_OFS_TARGET_B: reg_rdata <= target_temperature[2];
        `DFT_OFS_CTL_ONE:  reg_rdata <= dynamic_control_one;
        `DFT_OFS_CTL_TWO:  reg_rdata <= dynamic_control_two;
        `DFT_OFS_LOW_A:    reg_rdata <= low_limit[0];
        `DFT_OFS_HIGH_A:   reg_rdata <= high_limit[0];
        `DFT_OFS_LOW_L:    reg_rdata <= low_limit[1];
        `DFT_OFS_HIGH_L:   reg_rdata <= high_limit[1];
        `DFT_OFS_LOW_B:    reg_rdata <= low_limit[2];
        `DFT_OFS_HIGH_B:   reg_rdata <= high_limit[2];
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // Per-channel loop
  for (genvar i = 0; i < 3; i++) begin : g_ch

    logic signed [12:0] temp_q;
    logic signed [12:0] prev_q;
    logic signed [12:0] rise_q;
    logic signed [12:0] target_q;
    logic signed [12:0] lower_q;
    logic signed [12:0] low_q;
    logic signed [12:0] high_q;
    logic signed [12:0] thr_q;
    logic signed [12:0] floor_q;
    logic signed [12:0] next_q;
    logic [7:0]         next_fan_on_threshold;
    logic               below_low;
    logic               above_high;
    logic               was_below_low;
    logic               was_above_high;

    // Short and long cycle timing per channel
    dft_cycle_timer u_timer (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .tick        (monitor_tick),
      .code        (period_code[i]),
      .short_pulse (short_pulse[i]),
      .long_pulse  (long_pulse[i])
    );

    // All comparisons in signed quarter degrees
    // Whole degrees widened to quarters, then the fraction added on
    assign temp_q   = to_q(to_deg(temperature[i].code, offset64_mode)) +
                      $signed({11'h000, temperature[i].frac});
    assign target_q = to_q(to_deg(target_temperature[i], offset64_mode));
    assign low_q    = to_q(to_deg(low_limit[i], offset64_mode));
    assign high_q   = to_q(to_deg(high_limit[i], offset64_mode));
    assign thr_q    = to_q(to_deg(fan_on_threshold[i], offset64_mode));
    assign lower_q  = target_q - $signed({3'b000, hysteresis[i], 2'b00});
    assign rise_q   = temp_q - prev_q;
    assign floor_q  = offset64_mode ? $signed(`DFT_FLOOR_O64_Q)
                                    : $signed(`DFT_FLOOR_TC_Q);
    assign below_low  = temp_q < low_q;
    assign above_high = temp_q > high_q;

    // Temperature reference for the rise seen over one short cycle
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        prev_q <= 13'h0000;
      end else if (short_pulse[i]) begin
        prev_q <= temp_q;
      end
    end

    // Next threshold; adjustment is skipped while disabled or while the
    // temperature sits below the threshold, so the value simply holds
    always_comb begin
      next_q = thr_q;
      if (adjust_enable[i] && !(temp_q < thr_q)) begin
        // Short cycle: two degrees per whole degree of rise, so a
        // quarter-degree rise rounds to nothing
        if (short_pulse[i] && temp_q > lower_q && rise_q > 13'sh0000) begin
          next_q = next_q - $signed({rise_q[11:1], 2'b00});
        end
        // Long cycle: one degree down only above target or high limit
        if (long_pulse[i] && (temp_q > target_q || above_high)) begin
          next_q = next_q - 13'sh0004;
        end
        // Long cycle raise needs all four conditions
        if (long_pulse[i] && below_low && thr_q < high_q &&
            thr_q < target_q && temp_q > thr_q) begin
          next_q = next_q + 13'sh0004;
        end
        // Clamp to floor, and to the high limit or the present threshold, whichever is higher
        if (next_q < floor_q) begin
          next_q = floor_q;
        end
        if (next_q > high_q && next_q > thr_q) begin
          next_q = (thr_q > high_q) ? thr_q : high_q;
        end
      end
      next_fan_on_threshold = to_code(next_q[11:2], offset64_mode);
    end

    // Threshold register; a preload from the fan setup wins
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        fan_on_threshold[i] <= `DFT_RST_THRESHOLD;
      end else if (thr_load[i].load) begin
        fan_on_threshold[i] <= thr_load[i].value;
      end else begin
        fan_on_threshold[i] <= next_fan_on_threshold;
      end
    end

    // Limit crossings, judged once per monitoring cycle; a pulse on the
    // crossing only, so a long stay outside a limit does not flood
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        was_below_low  <= 1'b0;
        was_above_high <= 1'b0;
        low_event[i]   <= 1'b0;
        high_event[i]  <= 1'b0;
      end else begin
        low_event[i]  <= monitor_tick && below_low && !was_below_low;
        high_event[i] <= monitor_tick && above_high && !was_above_high;
        if (monitor_tick) begin
          was_below_low  <= below_low;
          was_above_high <= above_high;
        end
      end
    end

  end

endmodule

// ---- bench/dft_loop_asserts.sv ----
// Watches the register port, the thresholds and the event pulses
module dft_loop_asserts (
  input wire logic                         clk_sys,
  input wire logic                         nrst,
  input wire dft_pkg::dft_reg_req_t        reg_req,
  input wire logic [7:0]                   reg_rdata,
  input wire logic                         monitor_tick,
  input wire dft_pkg::dft_thr_load_t [2:0] thr_load,
  input wire logic [2:0][7:0]              fan_on_threshold,
  input wire logic [2:0]                   low_event,
  input wire logic [2:0]                   high_event
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic any_load;
  logic unmapped;
  // A threshold may only move after a cycle end or a preload
  assign any_load = |{thr_load[2].load, thr_load[1].load, thr_load[0].load};
  assign unmapped = !(reg_req.addr inside {[8'h33:8'h37], [8'h4E:8'h53]});
  a_unmapped_read: assert property
    (reg_req.rd && unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property
    (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_limit_readback: assert property
    (reg_req.wr && reg_req.addr == 8'h50 ##2 reg_req.rd &&
     reg_req.addr == 8'h50 |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("limit readback differs");
  a_thr_cause: assert property
    ($changed(fan_on_threshold) |-> $past(monitor_tick, 2) ||
     $past(monitor_tick, 3) || $past(any_load))
    else $error("threshold moved with no cause");
  a_load_wins: assert property
    (thr_load[0].load |=> fan_on_threshold[0] == $past(thr_load[0].value))
    else $error("preload not taken");
  a_low_on_tick: assert property
    (|low_event |-> $past(monitor_tick))
    else $error("low event without tick");
  a_high_on_tick: assert property
    (|high_event |-> $past(monitor_tick))
    else $error("high event without tick");
  a_low_single: assert property
    (|low_event |=> (low_event & $past(low_event)) == 3'b000)
    else $error("low event longer than one cycle");
  a_high_single: assert property
    (|high_event |=> (high_event & $past(high_event)) == 3'b000)
    else $error("high event longer than one cycle");
endmodule

bind dft_loop dft_loop_asserts u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
  .thr_load(thr_load), .fan_on_threshold(fan_on_threshold),
  .low_event(low_event), .high_event(high_event));

// ---- bench/dft_loop_test.sv ----
module dft_loop_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                         clk_sys = 1'b0;
  logic                         nrst = 1'b0;
  dft_pkg::dft_reg_req_t        reg_req = '0;
  logic [7:0]                   reg_rdata;
  logic                         monitor_tick = 1'b0;
  dft_pkg::dft_temp_t [2:0]     temperature = '0;
  logic [2:0][7:0]              hysteresis = {3{8'h05}};
  dft_pkg::dft_thr_load_t [2:0] thr_load = '0;
  logic [2:0][7:0]              fan_on_threshold;
  logic [2:0]                   low_event;
  logic [2:0]                   high_event;
  logic                         count_on = 1'b0;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  int lo_cnt[3] = '{0, 0, 0}, hi_cnt[3] = '{0, 0, 0};
  int regm[int];
  int code[3] = '{0, 1, 4};
  int offs[$] = '{'h33, 'h34, 'h35, 'h36, 'h37, 'h4E, 'h4F, 'h50,
                  'h51, 'h52, 'h53};
  logic [15:0] t5[] = '{16'h4E39, 16'h5039, 16'h5138, 16'h5360,
                        16'h3360, 16'h3460, 16'h3661};

  dft_loop u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
    .offset64_mode(1'b0), .temperature(temperature),
    .hysteresis(hysteresis), .thr_load(thr_load),
    .fan_on_threshold(fan_on_threshold), .low_event(low_event),
    .high_event(high_event));

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  // Hang guard and event tally; the tally window is opened only in the raise test
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (count_on) for (int i = 0; i < 3; i++) begin
      lo_cnt[i] += int'(low_event[i]);
      hi_cnt[i] += int'(high_event[i]);
    end
    if (cycles == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    reg_req <= '0;
    regm[a] = d;
  endtask

  // Read data lands at the edge that takes the strobe
  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    reg_req <= '0;
    #1 chk(reg_rdata, regm.exists(a) ? 8'(regm[a]) : 8'h00);
  endtask

  // Ticks spaced four cycles apart, well above the minimum spacing
  task automatic ticks(int n);
    repeat (n) begin
      @(posedge clk_sys);
      monitor_tick <= 1'b1;
      @(posedge clk_sys);
      monitor_tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask

  task automatic load(int i, logic [7:0] v);
    @(posedge clk_sys);
    thr_load[i] <= '{1'b1, v};
    @(posedge clk_sys);
    thr_load[i] <= '0;
  endtask

  task automatic temp(int i, logic [7:0] c, logic [1:0] f);
    @(posedge clk_sys);
    temperature[i] <= '{c, f};
  endtask

  task automatic chkt(int i, logic [7:0] e);
    repeat (2) @(posedge clk_sys);
    #1 chk(fan_on_threshold[i], e);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'hCDAB));
    foreach (offs[i]) regm[offs[i]] = offs[i] < 'h36 ? 'hA4 :
      offs[i] < 'h4E ? 0 : offs[i] % 2 ? 'h7F : 'h01;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (offs[i]) rd(8'(offs[i]));
    rd(8'h40);
    $display("test reset done");
    foreach (offs[i]) begin
      wr(8'(offs[i]), 8'($urandom));
      rd(8'(offs[i]));
    end
    $display("test regs done");
    // Targets 0x40, default limits, codes 0, 1 and 4, all enabled
    foreach (offs[i]) wr(8'(offs[i]), offs[i] < 'h36 ? 8'h40 :
      offs[i] % 2 ? 8'h7F : 8'h01);
    wr(8'h37, 8'h08);
    wr(8'h36, 8'hE1);
    temperature <= {3{10'h140}};
    ticks(256);
    for (int i = 0; i < 3; i++) load(i, 8'h30);
    ticks(256);
    foreach (code[i]) chkt(i, 8'(8'h30 - 256 / (16 << code[i])));
    $display("test long cycle done");
    // Only channel 0 adjusts; it sits between target less hysteresis and target
    wr(8'h36, 8'h21);
    temp(0, 8'h3C, 2'h0);
    load(0, 8'h20);
    ticks(16);
    chkt(0, 8'h20);
    temp(0, 8'h3C, 2'h1);
    ticks(8);
    chkt(0, 8'h20);
    temp(0, 8'h3E, 2'h1);
    ticks(8);
    chkt(0, 8'h20 - 8'(2 * 2));
    ticks(16);
    chkt(0, 8'h1C);
    chkt(1, 8'h28);
    $display("test short cycle done");
    foreach (t5[i]) wr(t5[i][15:8], t5[i][7:0]);
    temp(0, 8'h38, 2'h0);
    temp(1, 8'h38, 2'h0);
    temp(2, 8'h65, 2'h0);
    load(0, 8'h30);
    load(1, 8'h30);
    count_on = 1'b1;
    ticks(192);
    count_on = 1'b0;
    chkt(0, 8'h38);
    chkt(1, 8'(8'h30 + 192 / 32));
    for (int i = 0; i < 3; i++) begin
      chk(8'(lo_cnt[i]), 8'(i < 2));
      chk(8'(hi_cnt[i]), 8'(i == 2));
    end
    temp(0, 8'h3A, 2'h0);
    ticks(32);
    chkt(0, 8'h38);
    $display("test raise done");
    // Remote B alone, code 0; above its high limit and its target
    wr(8'h36, 8'h80);
    load(2, 8'h70);
    ticks(32);
    chkt(2, 8'h70);
    load(2, 8'h50);
    ticks(32);
    chkt(2, 8'h4E);
    $display("test suspend done");
    give_verdict();
  end
endmodule
